// ---- logic/squib_deploy_spi.sv ----
/*
 Serial frame interpreter for an eight-channel squib deployment driver:
 register mode, command mode, per-channel stretch and deployment timers,
 soft reset key, and a classic Wishbone slave for status and control.
 Assumes the host drives sclk/cs/mosi asynchronously to clk_in, clock
 idles low, data sampled on rising sclk, msb first, and the Wishbone
 master runs on clk_in.
*/
// The Wishbone slave port and the placing of the registers are this design's own decisions.
`include "squib_map.svh"
`timescale 1ns/100ps
`default_nettype none

module squib_deploy_spi
    import squib_pkg::*;
#(
    parameter int CHANNELS = 8,
    parameter int TICK_CYCLES = `TICK_CYCLES
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Serial link from the host
    input wire logic sclk_in,
    input wire logic cs_n_in,
    input wire logic mosi_in,
    output logic miso_out,
    output logic miso_oe_n_out,
    // Arming inputs and deployment drive
    input wire logic [CHANNELS-1:0] arm_in,
    output logic [CHANNELS-1:0] fire_out,
    output logic high_current_out,
    // Wishbone slave
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [7:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out
);

    localparam int TW = 8;

    function automatic logic [TW-1:0] ticks_of(input int us);
        ticks_of = TW'(us / `TICK_TIME_US);
    endfunction

    function automatic logic [TW-1:0] stretch_ticks(input logic [1:0] sel);
        case (sel)
            2'h0: stretch_ticks = ticks_of(`STRETCH_00_US);
            2'h1: stretch_ticks = ticks_of(`STRETCH_01_US);
            2'h2: stretch_ticks = ticks_of(`STRETCH_10_US);
            default: stretch_ticks = ticks_of(`STRETCH_11_US);
        endcase
    endfunction

    // Two-stage synchronisers for the pins
    logic [2:0] pin_meta_reg;
    logic [2:0] pin_sync_reg;
    logic [CHANNELS-1:0] arm_meta_reg;
    logic [CHANNELS-1:0] arm_sync_reg;
    logic [CHANNELS-1:0] arm_prev_reg;
    logic sclk_prev_reg;
    logic cs_prev_reg;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pin_meta_reg <= 3'h2; // Idle levels, so no false sclk edge after reset
            pin_sync_reg <= 3'h2;
            sclk_prev_reg <= 1'b0;
            cs_prev_reg <= 1'b1;
            arm_meta_reg <= '0;
            arm_sync_reg <= '0;
            arm_prev_reg <= '0;
        end else begin
            pin_meta_reg <= {mosi_in, cs_n_in, sclk_in};
            pin_sync_reg <= pin_meta_reg;
            sclk_prev_reg <= pin_sync_reg[0];
            cs_prev_reg <= pin_sync_reg[1];
            arm_meta_reg <= arm_in;
            arm_sync_reg <= arm_meta_reg;
            arm_prev_reg <= arm_sync_reg;
        end
    end

    logic sclk_rise;
    logic sclk_fall;
    logic cs_fall;
    logic cs_rise;
    logic cs_active;
    assign sclk_rise = pin_sync_reg[0] & ~sclk_prev_reg;
    assign sclk_fall = ~pin_sync_reg[0] & sclk_prev_reg;
    assign cs_fall = ~pin_sync_reg[1] & cs_prev_reg;
    assign cs_rise = pin_sync_reg[1] & ~cs_prev_reg;
    assign cs_active = ~pin_sync_reg[1];

    // Receive shift and bit count
    logic [15:0] rx_reg;
    logic [4:0] bit_cnt_reg;
    logic frame_done;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rx_reg <= '0;
            bit_cnt_reg <= '0;
        end else if (cs_fall) begin
            bit_cnt_reg <= '0;
        end else if (cs_active && sclk_rise) begin
            rx_reg <= {rx_reg[14:0], pin_sync_reg[2]};
            if (bit_cnt_reg <= 5'(`FRAME_BITS))
                bit_cnt_reg <= bit_cnt_reg + 5'h1;
        end
    end

    // Only exactly sixteen clocks make a valid frame
    assign frame_done = cs_rise && (bit_cnt_reg == 5'(`FRAME_BITS));

    logic parity_ok;
    frame_mode_t mode;
    logic is_reg_write;
    logic is_key_frame;
    logic is_cmd;
    assign parity_ok = ^rx_reg;
    assign mode = frame_mode_t'(rx_reg[`FRAME_MODE_HI:`FRAME_MODE_LO]);
    assign is_reg_write = frame_done && parity_ok && (mode == MODE_REGISTER)
        && rx_reg[`FRAME_WRITE_BIT];
    assign is_key_frame = is_reg_write && rx_reg[`FRAME_SEL_BIT];
    assign is_cmd = frame_done && parity_ok && (mode == MODE_COMMAND);

    // Driver state
    logic profile_reg;
    logic [1:0] period_reg;
    logic [CHANNELS-1:0] deploy_reg;
    logic [CHANNELS-1:0] stretch_reg;
    logic arm_en_reg;
    key_state_t key_reg;
    logic soft_rst;
    logic tick;

    // Soft reset only with first key just before and nothing deploying
    assign soft_rst = is_key_frame && (key_reg == KEY_FIRST_SEEN)
        && (rx_reg[`FRAME_KEY_HI:`FRAME_KEY_LO] == `KEY_SECOND)
        && (deploy_reg == '0);

    // Key sequencer: any other valid frame breaks it
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            key_reg <= KEY_IDLE;
        end else if (frame_done) begin
            case (key_reg)
                KEY_IDLE: key_reg <= (is_key_frame && deploy_reg == '0
                    && rx_reg[`FRAME_KEY_HI:`FRAME_KEY_LO] == `KEY_FIRST)
                    ? KEY_FIRST_SEEN : KEY_IDLE;
                KEY_FIRST_SEEN: key_reg <= KEY_IDLE;
                default: key_reg <= KEY_IDLE;
            endcase
        end
    end

    // Deployment profile and stretch period
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            profile_reg <= `PROFILE_RESET;
            period_reg <= `PERIOD_RESET;
        end else if (soft_rst) begin
            profile_reg <= `PROFILE_RESET;
            period_reg <= `PERIOD_RESET;
        end else if (is_reg_write) begin
            profile_reg <= rx_reg[`FRAME_PROFILE_BIT];
            if (!rx_reg[`FRAME_SEL_BIT])
                period_reg <= rx_reg[`FRAME_PERIOD_HI:`FRAME_PERIOD_LO];
        end
    end

    // Tick prescaler, half a millisecond per tick
    logic [$clog2(TICK_CYCLES)-1:0] pre_reg;
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pre_reg <= '0;
            tick <= 1'b0;
        end else begin
            tick <= (pre_reg == $bits(pre_reg)'(TICK_CYCLES - 1));
            if (pre_reg == $bits(pre_reg)'(TICK_CYCLES - 1))
                pre_reg <= '0;
            else
                pre_reg <= pre_reg + $bits(pre_reg)'(1);
        end
    end

    // One extra tick so a partial first tick never shortens a period
    logic [TW-1:0] deploy_load;
    logic [TW-1:0] stretch_load;
    assign deploy_load = (profile_reg ? ticks_of(`DEPLOY_SHORT_US)
        : ticks_of(`DEPLOY_LONG_US)) + TW'(1);
    assign stretch_load = stretch_ticks(period_reg) + TW'(1);

    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch++) begin : g_chan
            logic [TW-1:0] dep_cnt_reg;
            logic [TW-1:0] str_cnt_reg;
            logic cmd_on;
            logic cmd_off;
            logic armed;
            assign cmd_on = is_cmd && rx_reg[ch] && !deploy_reg[ch];
            assign cmd_off = is_cmd && !rx_reg[ch] && !deploy_reg[ch];
            assign armed = arm_en_reg && arm_sync_reg[ch];

            // Deployment: nothing but its own count ends it
            always_ff @(posedge clk_in or posedge rst_in) begin
                if (rst_in) begin
                    deploy_reg[ch] <= 1'b0;
                    dep_cnt_reg <= '0;
                end else if (cmd_on && (armed || stretch_reg[ch])) begin
                    deploy_reg[ch] <= 1'b1;
                    dep_cnt_reg <= deploy_load;
                end else if (deploy_reg[ch] && tick) begin
                    if (dep_cnt_reg == TW'(1))
                        deploy_reg[ch] <= 1'b0;
                    dep_cnt_reg <= dep_cnt_reg - TW'(1);
                end
            end

            // Stretch timer
            always_ff @(posedge clk_in or posedge rst_in) begin
                if (rst_in) begin
                    stretch_reg[ch] <= 1'b0;
                    str_cnt_reg <= '0;
                end else if (soft_rst) begin
                    stretch_reg[ch] <= 1'b0;
                end else if (cmd_on || (armed && !arm_prev_reg[ch])) begin
                    stretch_reg[ch] <= 1'b1;
                    str_cnt_reg <= stretch_load;
                end else if (cmd_off) begin
                    stretch_reg[ch] <= 1'b0;
                end else if (stretch_reg[ch] && tick) begin
                    if (str_cnt_reg == TW'(1))
                        stretch_reg[ch] <= 1'b0;
                    str_cnt_reg <= str_cnt_reg - TW'(1);
                end
            end
        end
    endgenerate

    // Reply for the next frame; soft reset leaves it alone
    logic [15:0] resp_reg;
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            resp_reg <= '0;
        end else if (frame_done) begin
            if (!parity_ok)
                resp_reg <= {`RESP_FAULT, 13'h0};
            else
                case (mode)
                    MODE_REGISTER: resp_reg <= {`RESP_REGISTER, 10'h0,
                        rx_reg[`FRAME_WRITE_BIT] ? rx_reg[`FRAME_PROFILE_BIT] : profile_reg,
                        (rx_reg[`FRAME_WRITE_BIT] && !rx_reg[`FRAME_SEL_BIT])
                        ? rx_reg[`FRAME_PERIOD_HI:`FRAME_PERIOD_LO] : period_reg};
                    MODE_COMMAND: resp_reg <= {`RESP_COMMAND, 5'h0, 8'(deploy_reg)};
                    MODE_DIAG: resp_reg <= {`RESP_DIAG, 13'h0};
                    default: resp_reg <= {`RESP_MONITOR, 13'h0};
                endcase
        end
    end

    // Transmit: loaded at select, next bit on each falling sclk
    logic [15:0] tx_reg;
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            tx_reg <= '0;
            miso_out <= 1'b0;
            miso_oe_n_out <= 1'b1;
        end else begin
            miso_oe_n_out <= !cs_active;
            if (cs_fall) begin
                tx_reg <= {resp_reg[14:0], 1'b0};
                miso_out <= resp_reg[15];
            end else if (cs_active && sclk_fall) begin
                tx_reg <= {tx_reg[14:0], 1'b0};
                miso_out <= tx_reg[15];
            end
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            fire_out <= '0;
            high_current_out <= 1'b0;
        end else begin
            fire_out <= deploy_reg;
            high_current_out <= profile_reg;
        end
    end

    // Wishbone slave, outside the soft reset domain
    logic [15:0] fault_cnt_reg;
    logic wb_req;
    logic wb_wr;
    assign wb_req = wb_cyc_in && wb_stb_in && !wb_ack_out;
    assign wb_wr = wb_req && wb_we_in && wb_sel_in[0];

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            arm_en_reg <= `ARM_EN_RESET;
        end else if (wb_wr && wb_adr_in == `ADDR_CONTROL) begin
            arm_en_reg <= wb_dat_in[`CTRL_ARM_EN_BIT];
        end
    end

    // Fault count: a new fault wins over a clear in the same cycle
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in)
            fault_cnt_reg <= '0;
        else if (frame_done && !parity_ok)
            fault_cnt_reg <= (wb_wr && wb_adr_in == `ADDR_FAULTS) ? 16'h1
                : fault_cnt_reg + ((fault_cnt_reg == 16'hffff) ? 16'h0 : 16'h1);
        else if (wb_wr && wb_adr_in == `ADDR_FAULTS)
            fault_cnt_reg <= '0;
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            wb_ack_out <= 1'b0;
            wb_dat_out <= '0;
        end else begin
            wb_ack_out <= wb_req;
            wb_dat_out <= '0;
            if (wb_req && !wb_we_in)
                case (wb_adr_in)
                    `ADDR_STATUS: begin
                        wb_dat_out[`STAT_DEPLOY_LO +: 8] <= 8'(deploy_reg);
                        wb_dat_out[`STAT_STRETCH_LO +: 8] <= 8'(stretch_reg);
                        wb_dat_out[`STAT_PROFILE_BIT] <= profile_reg;
                        wb_dat_out[`STAT_PERIOD_LO +: 2] <= period_reg;
                        wb_dat_out[`STAT_KEY_BIT] <= (key_reg == KEY_FIRST_SEEN);
                    end
                    `ADDR_CONTROL: wb_dat_out[`CTRL_ARM_EN_BIT] <= arm_en_reg;
                    `ADDR_FAULTS: wb_dat_out[15:0] <= fault_cnt_reg;
                    default: wb_dat_out <= '0;
                endcase
        end
    end

endmodule // squib_deploy_spi

`default_nettype wire

// ---- logic/squib_map.svh ----
/*
 Constants for the squib deployment serial command block: frame fields,
 response codes, timing figures and the software register map.
 Assumes inclusion by its bare name from the design file.
*/
`ifndef SQUIB_MAP_SVH
`define SQUIB_MAP_SVH

// Frame layout
`define FRAME_BITS 16
`define FRAME_MODE_HI 15
`define FRAME_MODE_LO 14
`define FRAME_WRITE_BIT 12
`define FRAME_SEL_BIT 11
`define FRAME_PROFILE_BIT 10
`define FRAME_PERIOD_HI 9
`define FRAME_PERIOD_LO 8
`define FRAME_KEY_HI 7
`define FRAME_KEY_LO 0

// Soft reset keys
`define KEY_FIRST 8'haa
`define KEY_SECOND 8'h55

// Response mode codes, bits 15 to 13
`define RESP_REGISTER 3'h0
`define RESP_COMMAND 3'h2
`define RESP_DIAG 3'h4
`define RESP_MONITOR 3'h6
`define RESP_FAULT 3'h7

// Reset values
`define PROFILE_RESET 1'h0
`define PERIOD_RESET 2'h0
`define ARM_EN_RESET 1'h1

// Timing: clock rate and the timer tick
`define CLK_MHZ 250
`define TICK_TIME_US 500
`define TICK_CYCLES (`TICK_TIME_US * `CLK_MHZ)

// Stretch periods and deployment times in microseconds
`define STRETCH_00_US 7500
`define STRETCH_01_US 15000
`define STRETCH_10_US 30000
`define STRETCH_11_US 60000
`define DEPLOY_LONG_US 2000
`define DEPLOY_SHORT_US 1000

// Software register byte offsets
`define ADDR_STATUS 8'h00
`define ADDR_CONTROL 8'h04
`define ADDR_FAULTS 8'h08

// Status and control fields
`define STAT_DEPLOY_LO 0
`define STAT_STRETCH_LO 8
`define STAT_PROFILE_BIT 16
`define STAT_PERIOD_LO 17
`define STAT_KEY_BIT 19
`define CTRL_ARM_EN_BIT 0

`endif

// ---- logic/squib_pkg.sv ----
/*
 Types for the squib deployment serial command block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package squib_pkg;

    typedef enum logic [1:0] {
        MODE_REGISTER,
        MODE_COMMAND,
        MODE_DIAG,
        MODE_MONITOR
    } frame_mode_t;

    typedef enum logic {
        KEY_IDLE,
        KEY_FIRST_SEEN
    } key_state_t;

endpackage

// ---- verif/squib_deploy_spi_props.sv ----
/*
 Checker for the squib deployment serial command block.
 Assumes binding to the top module; sees only its ports.
*/
`timescale 1ns/100ps
`default_nettype none

module squib_deploy_spi_props #(
    parameter int CHANNELS = 8,
    parameter int TICK_CYCLES = 125000
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Observed ports
    input wire logic cs_n_in,
    input wire logic miso_oe_n_out,
    input wire logic [CHANNELS-1:0] fire_out,
    input wire logic high_current_out,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic [31:0] wb_dat_out,
    input wire logic wb_ack_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    logic [31:0] fire_cnt_reg;
    logic fire_d_reg;
    logic prof_reg;

    // Profile latched at start, so a later profile write cannot skew the bound
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            fire_cnt_reg <= 32'h0;
            fire_d_reg <= 1'b0;
            prof_reg <= 1'b0;
        end else begin
            fire_cnt_reg <= fire_out[0] ? fire_cnt_reg + 32'h1 : 32'h0;
            fire_d_reg <= fire_out[0];
            if (fire_out[0] && !fire_d_reg) begin
                prof_reg <= high_current_out;
            end
        end
    end

    wb_ack_next_a: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
        else $error("ack missing one cycle after request");
    wb_ack_pulse_a: assert property (wb_ack_out |=> !wb_ack_out)
        else $error("ack longer than one cycle");
    wb_data_idle_a: assert property (!wb_ack_out |-> wb_dat_out == 32'h0)
        else $error("read data outside ack");
    miso_release_a: assert property (cs_n_in [*6] |-> miso_oe_n_out)
        else $error("data out driven while deselected");
    miso_drive_a: assert property (!cs_n_in [*6] |-> !miso_oe_n_out)
        else $error("data out not driven in frame");
    profile_frame_a: assert property ($changed(high_current_out) |-> cs_n_in && $past(cs_n_in))
        else $error("profile changed inside a frame");
    fire_start_a: assert property ((|(fire_out & ~$past(fire_out))) |-> cs_n_in && $past(cs_n_in))
        else $error("deployment started outside frame end");
    fire_len_a: assert property ($fell(fire_out[0]) |-> (prof_reg ?
        (fire_cnt_reg >= 2 * TICK_CYCLES - 2 && fire_cnt_reg <= 3 * TICK_CYCLES + 2) :
        (fire_cnt_reg >= 4 * TICK_CYCLES - 2 && fire_cnt_reg <= 5 * TICK_CYCLES + 2)))
        else $error("deployment length out of range");
endmodule // squib_deploy_spi_props

bind squib_deploy_spi squib_deploy_spi_props #(
    .CHANNELS(CHANNELS),
    .TICK_CYCLES(TICK_CYCLES)
) u_props (.*);

`default_nettype wire

// ---- verif/spi_host_model.sv ----
/*
 Host serial master model: sends one 16-bit frame per xfer call.
 Assumes clk_in free running; link clock runs only inside frames.
*/
`timescale 1ns/100ps
`default_nettype none

module spi_host_model #(
    parameter int HALF = 6
) (
    // Clock
    input wire logic clk_in,
    // Serial link
    input wire logic miso_in,
    output logic sclk_out,
    output logic cs_n_out,
    output logic mosi_out
);
    initial begin
        sclk_out = 1'b0;
        cs_n_out = 1'b1;
        mosi_out = 1'b0;
    end

    // Bad flag flips parity on purpose for fault frames
    task automatic xfer(input logic [15:0] data, input logic bad, output logic [15:0] rx);
        logic [15:0] tx;
        tx = data;
        tx[13] = (~^{data[15:14], data[12:0]}) ^ bad;
        cs_n_out <= 1'b0;
        mosi_out <= tx[15];
        repeat (HALF) @(posedge clk_in);
        for (int i = 15; i >= 0; i--) begin
            sclk_out <= 1'b1;
            rx[i] = miso_in;
            repeat (HALF) @(posedge clk_in);
            sclk_out <= 1'b0;
            if (i > 0) mosi_out <= tx[i-1];
            repeat (HALF) @(posedge clk_in);
        end
        cs_n_out <= 1'b1;
        // No pull on the line: released data shows the inverse
        mosi_out <= ~tx[0];
        repeat (10) @(posedge clk_in);
    endtask
endmodule // spi_host_model

`default_nettype wire

// ---- verif/tb_squib_deploy_spi.sv ----
/*
 Testbench for the squib deployment serial command block.
 Assumes the host model as serial master and a Wishbone task here.
*/
`timescale 1ns/100ps
`default_nettype none

`define CHECK_EQ(name, exp, got) begin num_checks++; if ((got) !== (exp)) begin \
    err_total++; $display("unexpected %s expected %h seen %h", name, exp, got); end end

module tb_squib_deploy_spi;
    localparam int TICK = 200;
    logic clk_in = 1'b0;
    logic rst_in, sclk, cs_n, mosi, miso, miso_oe_n, high_cur, wb_cyc, wb_stb, wb_we, wb_ack;
    logic [7:0] arm, fire, wb_adr;
    logic [31:0] wb_dat, wb_rdat, rd;
    logic [3:0] wb_sel;
    int err_total = 0;
    int num_checks = 0;
    int cycles = 0;

    always #2 clk_in = ~clk_in;

    squib_deploy_spi #(.CHANNELS(8), .TICK_CYCLES(TICK)) u_dut (.clk_in(clk_in),
        .rst_in(rst_in), .sclk_in(sclk), .cs_n_in(cs_n), .mosi_in(mosi), .miso_out(miso),
        .miso_oe_n_out(miso_oe_n), .arm_in(arm), .fire_out(fire), .high_current_out(high_cur),
        .wb_cyc_in(wb_cyc), .wb_stb_in(wb_stb), .wb_we_in(wb_we), .wb_adr_in(wb_adr),
        .wb_sel_in(wb_sel), .wb_dat_in(wb_dat), .wb_dat_out(wb_rdat), .wb_ack_out(wb_ack));
    spi_host_model #(.HALF(6)) u_host (.clk_in(clk_in), .miso_in(miso), .sclk_out(sclk),
        .cs_n_out(cs_n), .mosi_out(mosi));

    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Waits for ack without a count; only the bench timeout ends it
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                      output logic [31:0] rdat);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_sel <= 4'hf;
        wb_adr <= adr;
        wb_dat <= wd;
        do @(posedge clk_in); while (wb_ack !== 1'b1);
        rdat = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
        wb_sel <= 4'h0;
        @(posedge clk_in);
    endtask

    task automatic reg_chk(input logic [7:0] adr, input logic [31:0] exp);
        logic [31:0] r;
        wb(1'b0, adr, 32'h0, r);
        `CHECK_EQ($sformatf("register %h", adr), exp, r)
    endtask

    task automatic frame(input logic [15:0] tx, input logic bad, input logic chk,
                         input logic [15:0] exp);
        logic [15:0] rx;
        u_host.xfer(tx, bad, rx);
        if (chk) `CHECK_EQ("reply", exp, rx)
    endtask

    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            err_total++;
            results();
        end
    end

    initial begin
        rst_in = 1'b1;
        arm = 8'h00;
        wb_cyc = 1'b0;
        wb_stb = 1'b0;
        wb_we = 1'b0;
        wb_sel = 4'h0;
        wb_adr = 8'h00;
        wb_dat = 32'h0;
        repeat (2) @(posedge clk_in);
        rst_in <= 1'b0;
        repeat (4) @(posedge clk_in);
        `CHECK_EQ("fire", 8'h00, fire)
        `CHECK_EQ("profile", 1'b0, high_cur)
        reg_chk(8'h00, 32'h0);
        reg_chk(8'h04, 32'h1);
        reg_chk(8'h0c, 32'h0);
        frame(16'h0a5f, 1'b0, 1'b0, 16'h0);
        for (int p = 0; p < 4; p++) begin
            frame({5'h02, p[0], p[1:0], 8'hff}, 1'b0, 1'b0, 16'h0);
            frame(16'h0a5f, 1'b0, 1'b1, {13'h0, p[0], p[1:0]});
            `CHECK_EQ("profile", p[0], high_cur)
            reg_chk(8'h00, {13'h0, p[1:0], p[0], 16'h0});
        end
        frame(16'h8000, 1'b0, 1'b0, 16'h0);
        frame(16'hc000, 1'b0, 1'b1, 16'h8000);
        frame(16'h1000, 1'b1, 1'b1, 16'hc000);
        frame(16'h0000, 1'b0, 1'b1, 16'he000);
        frame(16'h0000, 1'b0, 1'b1, 16'h0007);
        reg_chk(8'h08, 32'h1);
        wb(1'b1, 8'h04, 32'h0, rd);
        frame(16'h18aa, 1'b0, 1'b0, 16'h0);
        frame(16'h0000, 1'b0, 1'b0, 16'h0);
        frame(16'h1855, 1'b0, 1'b0, 16'h0);
        reg_chk(8'h00, 32'h0006_0000);
        frame(16'h18aa, 1'b0, 1'b0, 16'h0);
        reg_chk(8'h00, 32'h000e_0000);
        frame(16'h1855, 1'b0, 1'b0, 16'h0);
        reg_chk(8'h00, 32'h0);
        reg_chk(8'h04, 32'h0);
        wb(1'b1, 8'h04, 32'h1, rd);
        frame(16'h5f08, 1'b0, 1'b0, 16'h0);
        reg_chk(8'h00, 32'h0000_0800);
        repeat (2880) @(posedge clk_in);
        reg_chk(8'h00, 32'h0000_0800);
        repeat (400) @(posedge clk_in);
        reg_chk(8'h00, 32'h0);
        frame(16'h4010, 1'b0, 1'b0, 16'h0);
        reg_chk(8'h00, 32'h0000_1000);
        frame(16'h4000, 1'b0, 1'b1, 16'h4000);
        reg_chk(8'h00, 32'h0);
        frame(16'h11ff, 1'b0, 1'b0, 16'h0);
        arm[0] <= 1'b1;
        repeat (10) @(posedge clk_in);
        reg_chk(8'h00, 32'h0002_0100);
        frame(16'h4001, 1'b0, 1'b1, 16'h0001);
        `CHECK_EQ("fire", 8'h01, fire)
        frame(16'h4002, 1'b0, 1'b1, 16'h4000);
        `CHECK_EQ("fire", 8'h01, fire)
        frame(16'h18aa, 1'b0, 1'b1, 16'h4001);
        frame(16'h1855, 1'b0, 1'b0, 16'h0);
        do @(posedge clk_in); while (fire !== 8'h00);
        reg_chk(8'h00, 32'h0002_0300);
        results();
    end
endmodule // tb_squib_deploy_spi

`default_nettype wire
